/* rtl/rmsc_defs.svh */
`ifndef RMSC_DEFS_SVH
`define RMSC_DEFS_SVH

// register addresses
`define RMSC_MODE_ADDR      12'h800
`define RMSC_STROBE_ADDR    12'h801
`define RMSC_CHAN_ADDR      12'h811
`define RMSC_BASE2_ADDR     12'h812
`define RMSC_BASE3_ADDR     12'h813
`define RMSC_STEP_ADDR      12'h814
`define RMSC_BUF_BASE_HI    6'h24
`define RMSC_BUF_DEPTH      7'h40

// mode register write / read bits
`define RMSC_SOFT_RESET_BIT 7
`define RMSC_CRC_FLAG_BIT   5
`define RMSC_CHIP_ON_BIT    4
`define RMSC_XTAL_ON_BIT    3
`define RMSC_PLL_ON_BIT     2
`define RMSC_TX_STATE_BIT   1
`define RMSC_TRX_ON_BIT     0

// strobe upper nibbles
`define RMSC_CMD_SLEEP      4'h8
`define RMSC_CMD_IDLE       4'h9
`define RMSC_CMD_STANDBY    4'hA
`define RMSC_CMD_SYNTH      4'hB
`define RMSC_CMD_RX         4'hC
`define RMSC_CMD_TX         4'hD

// reset values and crc polynomial
`define RMSC_REG_RESET      8'h00
`define RMSC_CRC_INIT       16'hFFFF
`define RMSC_CRC_POLY       16'h1021

// lo frequency in half-MHz units: 2400 MHz
`define RMSC_LO_BASE_HALF   13'h12C0
// channel step lsb position inside 15-bit step
`define RMSC_STEP_SHIFT     7
// system clock divide from csck (32 or 64 MHz) to 8 MHz
`define RMSC_SYCK_DIV_LOW   4'h4
`define RMSC_SYCK_DIV_HIGH  4'h8

`endif

/* rtl/rmsc_pkg.sv */
`default_nettype none
`include "rmsc_defs.svh"

package rmsc_pkg;

	typedef enum logic [2:0] {
		RMSC_SLEEP,
		RMSC_IDLE,
		RMSC_STANDBY,
		RMSC_SYNTH,
		RMSC_RX,
		RMSC_TX
	} rmsc_state_t;

	typedef enum logic [2:0] {
		TXP_IDLE,
		TXP_FETCH,
		TXP_LOAD,
		TXP_SEND,
		TXP_CRC_HI,
		TXP_CRC_LO,
		TXP_DONE
	} rmsc_txp_t;

	function automatic logic [15:0] rmsc_crc16(input logic [15:0] crc, input logic [7:0] data);
		logic [15:0] c;
		c = crc;
		for (int i = 7; i >= 0; i--) begin
			if (c[15] ^ data[i]) begin
				c = {c[14:0], 1'b0} ^ `RMSC_CRC_POLY;
			end else begin
				c = {c[14:0], 1'b0};
			end
		end
		return c;
	endfunction : rmsc_crc16

	function automatic logic rmsc_is_buf(input logic [11:0] addr);
		return addr[11:6] == `RMSC_BUF_BASE_HI;
	endfunction : rmsc_is_buf

endpackage : rmsc_pkg

`default_nettype wire

/* rtl/rmsc_buf_mem.sv */
`default_nettype none
`include "rmsc_defs.svh"

module rmsc_buf_mem (
	input  wire logic       mclk_in,
	input  wire logic       rst_in,
	input  wire logic       wr_en_in,
	input  wire logic [5:0] wr_addr_in,
	input  wire logic [7:0] wr_data_in,
	input  wire logic [5:0] rd_addr_in,
	output logic      [7:0] rd_data_out
);

	logic [7:0] mem [0:63];

	always_ff @(posedge mclk_in) begin
		if (wr_en_in) begin
			mem[wr_addr_in] <= wr_data_in;
		end
	end

	always_ff @(posedge mclk_in or posedge rst_in) begin
		if (rst_in) begin
			rd_data_out <= `RMSC_REG_RESET;
		end else begin
			rd_data_out <= mem[rd_addr_in];
		end
	end

endmodule : rmsc_buf_mem

`default_nettype wire

/* rtl/rmsc_top.sv */
`default_nettype none
`include "rmsc_defs.svh"

// Functional notes
// - fifo mode crc on: append two crc bytes
// - check received crc, set result flag
// - never receive and transmit together
// - lo frequency is 2400 plus half channel
// - reference tick every divider plus one
// - offset is channel times channel step
// - upper strobe nibble selects state
// - per-state oscillator, pll, rx, tx enables
// - exactly six operating states
// - fifo mode select enables packet mode
// - one tx strobe sends whole packet
// - finished transmit returns to standby
// - soft reset pulses radio reset, standby
// - two 64-byte buffers share one window
module rmsc_top
	import rmsc_pkg::*;
(
	input  wire logic        mclk_in,
	input  wire logic        rst_in,
	input  wire logic [11:0] addr_in,
	input  wire logic        wr_en_in,
	input  wire logic        rd_en_in,
	input  wire logic [7:0]  wdata_in,
	output logic      [7:0]  rdata_out,
	output logic             rdata_valid_out,
	input  wire logic        crc_enable_in,
	input  wire logic        fifo_mode_select_in,
	input  wire logic [3:0]  ref_divider_in,
	input  wire logic        bandwidth_select_in,
	output logic      [7:0]  tx_data_out,
	output logic             tx_valid_out,
	input  wire logic        tx_ready_in,
	input  wire logic [7:0]  rx_data_in,
	input  wire logic        rx_valid_in,
	input  wire logic        rx_end_in,
	output logic             regulator_en_out,
	output logic             xtal_en_out,
	output logic             vco_en_out,
	output logic             pll_en_out,
	output logic             rx_en_out,
	output logic             tx_en_out,
	output logic             radio_soft_reset_out,
	output logic      [7:0]  base_integer_part_out,
	output logic      [15:0] base_fraction_part_out,
	output logic      [22:0] lo_offset_out,
	output logic      [12:0] lo_frequency_out,
	output logic             cgr_tick_out,
	output logic      [3:0]  syck_div_out
);

	rmsc_state_t rf_state,        next_rf_state;
	rmsc_txp_t   tx_phase,        next_tx_phase;
	logic [7:0]  channel_number,  next_channel_number;
	logic [7:0]  synth_base_reg_two, next_synth_base_reg_two;
	logic [7:0]  synth_base_reg_three, next_synth_base_reg_three;
	logic [7:0]  channel_step_reg, next_channel_step_reg;
	logic [6:0]  tx_idx,          next_tx_idx;
	logic [6:0]  tx_len,          next_tx_len;
	logic [15:0] tx_crc,          next_tx_crc;
	logic [6:0]  rx_idx,          next_rx_idx;
	logic [15:0] rx_crc,          next_rx_crc;
	logic        crc_result_flag, next_crc_result_flag;
	logic [3:0]  ref_cnt,         next_ref_cnt;
	logic        rd_pend;
	logic [11:0] rd_addr_q;
	logic [7:0]  next_rdata_out;
	logic [7:0]  next_tx_data_out;
	logic        next_tx_valid_out;
	logic        next_xtal, next_vco, next_pll, next_rx, next_tx, next_soft_reset;
	logic [22:0] next_lo_offset;
	logic [12:0] next_lo_frequency;
	logic        next_cgr_tick;
	logic        soft_rst_wr, strobe_wr, buf_wr, rx_store;
	logic [7:0]  tx_rd_data, rx_rd_data, status_byte;
	logic [14:0] channel_step_value;

	assign soft_rst_wr = wr_en_in && addr_in == `RMSC_MODE_ADDR && wdata_in[`RMSC_SOFT_RESET_BIT];
	assign strobe_wr   = wr_en_in && addr_in == `RMSC_STROBE_ADDR;
	assign buf_wr      = wr_en_in && rmsc_is_buf(addr_in);
	assign rx_store    = rf_state == RMSC_RX && rx_valid_in && rx_idx < `RMSC_BUF_DEPTH;
	assign channel_step_value = {channel_step_reg, 7'h00};

	// tx buffer: bus writes, packet engine reads
	rmsc_buf_mem u_tx_buf (
		.mclk_in     (mclk_in),
		.rst_in      (rst_in),
		.wr_en_in    (buf_wr),
		.wr_addr_in  (addr_in[5:0]),
		.wr_data_in  (wdata_in),
		.rd_addr_in  (tx_idx[5:0]),
		.rd_data_out (tx_rd_data)
	);

	// rx buffer: receiver writes, bus reads
	rmsc_buf_mem u_rx_buf (
		.mclk_in     (mclk_in),
		.rst_in      (rst_in),
		.wr_en_in    (rx_store),
		.wr_addr_in  (rx_idx[5:0]),
		.wr_data_in  (rx_data_in),
		.rd_addr_in  (addr_in[5:0]),
		.rd_data_out (rx_rd_data)
	);

	always_comb begin
		status_byte = 8'h00;
		status_byte[`RMSC_CRC_FLAG_BIT] = crc_result_flag;
		status_byte[`RMSC_CHIP_ON_BIT]  = rf_state != RMSC_SLEEP;
		status_byte[`RMSC_XTAL_ON_BIT]  = xtal_en_out;
		status_byte[`RMSC_PLL_ON_BIT]   = pll_en_out;
		status_byte[`RMSC_TX_STATE_BIT] = tx_en_out;
		status_byte[`RMSC_TRX_ON_BIT]   = rx_en_out || tx_en_out;
	end

	always_comb begin
		next_rf_state             = rf_state;
		next_tx_phase             = tx_phase;
		next_channel_number       = channel_number;
		next_synth_base_reg_two   = synth_base_reg_two;
		next_synth_base_reg_three = synth_base_reg_three;
		next_channel_step_reg     = channel_step_reg;
		next_tx_idx               = tx_idx;
		next_tx_len               = tx_len;
		next_tx_crc               = tx_crc;
		next_rx_idx               = rx_idx;
		next_rx_crc               = rx_crc;
		next_crc_result_flag      = crc_result_flag;
		next_tx_data_out          = tx_data_out;
		next_tx_valid_out         = tx_valid_out;
		next_soft_reset           = soft_rst_wr;
		// synth and channel registers
		if (wr_en_in) begin
			unique case (addr_in)
				`RMSC_CHAN_ADDR:  next_channel_number       = wdata_in;
				`RMSC_BASE2_ADDR: next_synth_base_reg_two   = wdata_in;
				`RMSC_BASE3_ADDR: next_synth_base_reg_three = wdata_in;
				`RMSC_STEP_ADDR:  next_channel_step_reg     = wdata_in;
				default: ;
			endcase
		end
		if (buf_wr) begin
			next_tx_len = {1'b0, addr_in[5:0]} + 7'h01;
		end
		// receive path
		if (rf_state == RMSC_RX && rx_valid_in) begin
			next_rx_crc = rmsc_crc16(rx_crc, rx_data_in);
			if (rx_store) begin
				next_rx_idx = rx_idx + 7'h01;
			end
		end
		if (rf_state == RMSC_RX && rx_end_in && crc_enable_in) begin
			next_crc_result_flag = rx_crc == 16'h0000;
		end
		// packet transmit engine
		unique case (tx_phase)
			TXP_IDLE: ;
			TXP_FETCH: begin
				if (tx_idx == tx_len) begin
					next_tx_phase = crc_enable_in ? TXP_CRC_HI : TXP_DONE;
				end else begin
					next_tx_phase = TXP_LOAD;
				end
			end
			TXP_LOAD: begin
				next_tx_data_out  = tx_rd_data;
				next_tx_valid_out = 1'b1;
				next_tx_phase     = TXP_SEND;
			end
			TXP_SEND: begin
				if (tx_ready_in) begin
					next_tx_valid_out = 1'b0;
					next_tx_crc       = rmsc_crc16(tx_crc, tx_data_out);
					next_tx_idx       = tx_idx + 7'h01;
					next_tx_phase     = TXP_FETCH;
				end
			end
			TXP_CRC_HI: begin
				if (!tx_valid_out) begin
					next_tx_data_out  = tx_crc[15:8];
					next_tx_valid_out = 1'b1;
				end else if (tx_ready_in) begin
					next_tx_valid_out = 1'b0;
					next_tx_phase     = TXP_CRC_LO;
				end
			end
			TXP_CRC_LO: begin
				if (!tx_valid_out) begin
					next_tx_data_out  = tx_crc[7:0];
					next_tx_valid_out = 1'b1;
				end else if (tx_ready_in) begin
					next_tx_valid_out = 1'b0;
					next_tx_phase     = TXP_DONE;
				end
			end
			TXP_DONE: begin
				next_rf_state = RMSC_STANDBY;
				next_tx_phase = TXP_IDLE;
			end
			default: next_tx_phase = TXP_IDLE;
		endcase
		// strobe commands override the engine
		if (strobe_wr) begin
			unique case (wdata_in[7:4])
				`RMSC_CMD_SLEEP:   next_rf_state = RMSC_SLEEP;
				`RMSC_CMD_IDLE:    next_rf_state = RMSC_IDLE;
				`RMSC_CMD_STANDBY: next_rf_state = RMSC_STANDBY;
				`RMSC_CMD_SYNTH:   next_rf_state = RMSC_SYNTH;
				`RMSC_CMD_RX:      next_rf_state = RMSC_RX;
				`RMSC_CMD_TX:      next_rf_state = RMSC_TX;
				default:           next_rf_state = rf_state;
			endcase
			if (next_rf_state != rf_state || wdata_in[7:4] == `RMSC_CMD_TX
					|| wdata_in[7:4] == `RMSC_CMD_RX) begin
				next_tx_phase     = TXP_IDLE;
				next_tx_valid_out = 1'b0;
			end
			if (wdata_in[7:4] == `RMSC_CMD_TX && fifo_mode_select_in) begin
				next_tx_phase = TXP_FETCH;
				next_tx_idx   = 7'h00;
				next_tx_crc   = `RMSC_CRC_INIT;
			end
			if (wdata_in[7:4] == `RMSC_CMD_RX) begin
				next_rx_idx = 7'h00;
				next_rx_crc = `RMSC_CRC_INIT;
			end
		end
		if (soft_rst_wr) begin
			next_rf_state        = RMSC_STANDBY;
			next_tx_phase        = TXP_IDLE;
			next_tx_valid_out    = 1'b0;
			next_tx_len          = 7'h00;
			next_crc_result_flag = 1'b0;
		end
		// per-state enables
		next_xtal = next_rf_state inside {RMSC_STANDBY, RMSC_SYNTH, RMSC_RX, RMSC_TX};
		next_vco  = next_rf_state inside {RMSC_SYNTH, RMSC_RX, RMSC_TX};
		next_pll  = next_vco;
		next_rx   = next_rf_state == RMSC_RX;
		next_tx   = next_rf_state == RMSC_TX;
		// frequency plan
		next_lo_frequency = `RMSC_LO_BASE_HALF + {5'h00, channel_number};
		next_lo_offset    = {15'h0000, channel_number} * {8'h00, channel_step_value};
		// reference divider
		if (ref_cnt >= ref_divider_in) begin
			next_ref_cnt  = 4'h0;
			next_cgr_tick = 1'b1;
		end else begin
			next_ref_cnt  = ref_cnt + 4'h1;
			next_cgr_tick = 1'b0;
		end
		// register read mux
		next_rdata_out = rdata_out;
		if (rd_pend) begin
			if (rmsc_is_buf(rd_addr_q)) begin
				next_rdata_out = rx_rd_data;
			end else begin
				unique case (rd_addr_q)
					`RMSC_MODE_ADDR:  next_rdata_out = status_byte;
					`RMSC_CHAN_ADDR:  next_rdata_out = channel_number;
					`RMSC_BASE2_ADDR: next_rdata_out = synth_base_reg_two;
					`RMSC_BASE3_ADDR: next_rdata_out = synth_base_reg_three;
					`RMSC_STEP_ADDR:  next_rdata_out = channel_step_reg;
					default:          next_rdata_out = 8'h00;
				endcase
			end
		end
	end

	always_ff @(posedge mclk_in or posedge rst_in) begin
		if (rst_in) begin
			rf_state               <= RMSC_STANDBY;
			tx_phase               <= TXP_IDLE;
			channel_number         <= `RMSC_REG_RESET;
			synth_base_reg_two     <= `RMSC_REG_RESET;
			synth_base_reg_three   <= `RMSC_REG_RESET;
			channel_step_reg       <= `RMSC_REG_RESET;
			tx_idx                 <= 7'h00;
			tx_len                 <= 7'h00;
			tx_crc                 <= `RMSC_CRC_INIT;
			rx_idx                 <= 7'h00;
			rx_crc                 <= `RMSC_CRC_INIT;
			crc_result_flag        <= 1'b0;
			ref_cnt                <= 4'h0;
			rd_pend                <= 1'b0;
			rd_addr_q              <= 12'h000;
			rdata_out              <= 8'h00;
			rdata_valid_out        <= 1'b0;
			tx_data_out            <= 8'h00;
			tx_valid_out           <= 1'b0;
			regulator_en_out       <= 1'b1;
			xtal_en_out            <= 1'b1;
			vco_en_out             <= 1'b0;
			pll_en_out             <= 1'b0;
			rx_en_out              <= 1'b0;
			tx_en_out              <= 1'b0;
			radio_soft_reset_out   <= 1'b0;
			base_integer_part_out  <= 8'h00;
			base_fraction_part_out <= 16'h0000;
			lo_offset_out          <= 23'h000000;
			lo_frequency_out       <= `RMSC_LO_BASE_HALF;
			cgr_tick_out           <= 1'b0;
			syck_div_out           <= `RMSC_SYCK_DIV_LOW;
		end else begin
			rf_state               <= next_rf_state;
			tx_phase               <= next_tx_phase;
			channel_number         <= next_channel_number;
			synth_base_reg_two     <= next_synth_base_reg_two;
			synth_base_reg_three   <= next_synth_base_reg_three;
			channel_step_reg       <= next_channel_step_reg;
			tx_idx                 <= next_tx_idx;
			tx_len                 <= next_tx_len;
			tx_crc                 <= next_tx_crc;
			rx_idx                 <= next_rx_idx;
			rx_crc                 <= next_rx_crc;
			crc_result_flag        <= next_crc_result_flag;
			ref_cnt                <= next_ref_cnt;
			rd_pend                <= rd_en_in;
			rd_addr_q              <= addr_in;
			rdata_out              <= next_rdata_out;
			rdata_valid_out        <= rd_pend;
			tx_data_out            <= next_tx_data_out;
			tx_valid_out           <= next_tx_valid_out;
			regulator_en_out       <= 1'b1;
			xtal_en_out            <= next_xtal;
			vco_en_out             <= next_vco;
			pll_en_out             <= next_pll;
			rx_en_out              <= next_rx;
			tx_en_out              <= next_tx;
			radio_soft_reset_out   <= next_soft_reset;
			base_integer_part_out  <= synth_base_reg_two;
			base_fraction_part_out <= {8'h00, synth_base_reg_three};
			lo_offset_out          <= next_lo_offset;
			lo_frequency_out       <= next_lo_frequency;
			cgr_tick_out           <= next_cgr_tick;
			syck_div_out           <= bandwidth_select_in ? `RMSC_SYCK_DIV_HIGH : `RMSC_SYCK_DIV_LOW;
		end
	end

	default clocking cb @(posedge mclk_in); endclocking
	default disable iff (rst_in);

	sequence s_tx_launch;
		strobe_wr && !soft_rst_wr && wdata_in[7:4] == `RMSC_CMD_TX && fifo_mode_select_in && tx_len != 7'h00;
	endsequence
	sequence s_first_byte;
		tx_valid_out && tx_en_out;
	endsequence

	a_no_duplex: assert property (!(rx_en_out && tx_en_out)) else $error("rx and tx both on");
	a_strobe_select: assert property (strobe_wr && !soft_rst_wr && wdata_in[7:4] == `RMSC_CMD_SYNTH
		|=> rf_state == RMSC_SYNTH && pll_en_out && !rx_en_out) else $error("synth strobe ignored");
	a_unknown_keep: assert property (strobe_wr && !soft_rst_wr && wdata_in[7] == 1'b0 && tx_phase != TXP_DONE
		|=> $stable(rf_state)) else $error("unknown strobe moved state");
	a_tx_return: assert property (tx_phase == TXP_DONE && !strobe_wr
		|=> rf_state == RMSC_STANDBY && !tx_en_out && xtal_en_out) else $error("no return to standby");
	a_tx_launch: assert property (s_tx_launch |-> ##[2:3] s_first_byte) else $error("tx packet not launched");
	a_fifo_gate: assert property (strobe_wr && !fifo_mode_select_in && tx_phase == TXP_IDLE
		|=> tx_phase == TXP_IDLE) else $error("packet engine ran without fifo mode");
	a_crc_append: assert property (tx_phase == TXP_CRC_HI && tx_valid_out
		|-> tx_data_out == tx_crc[15:8] && crc_enable_in) else $error("crc high byte wrong");
	a_crc_check: assert property (rf_state == RMSC_RX && rx_end_in && crc_enable_in && !soft_rst_wr
		|=> crc_result_flag == ($past(rx_crc) == 16'h0000)) else $error("crc flag wrong");
	a_lo_freq: assert property (##1 lo_frequency_out == `RMSC_LO_BASE_HALF + {5'h00, $past(channel_number)})
		else $error("lo frequency wrong");
	a_lo_offset: assert property (##1 lo_offset_out == $past(channel_number) * $past(channel_step_value))
		else $error("lo offset wrong");
	a_ref_tick: assert property (cgr_tick_out && $stable(ref_divider_in) |-> ##1 !cgr_tick_out
		|| ref_divider_in == 4'h0) else $error("reference tick too close");
	a_soft_reset: assert property (soft_rst_wr |=> radio_soft_reset_out && rf_state == RMSC_STANDBY
		&& !tx_valid_out) else $error("soft reset missed");
	a_sleep_off: assert property (rf_state == RMSC_SLEEP |-> !xtal_en_out && !pll_en_out && !vco_en_out
		&& regulator_en_out) else $error("sleep enables wrong");

endmodule : rmsc_top

`default_nettype wire

/* verif/rmsc_modem_model.sv */
`default_nettype none

module rmsc_modem_model (
	input  wire logic       mclk_in,
	input  wire logic       slow_in,
	output logic            tx_ready_out,
	output logic      [7:0] rx_data_out,
	output logic            rx_valid_out,
	output logic            rx_end_out
);
	timeunit 1ns;
	timeprecision 1ps;

	logic [1:0] pace;

	initial begin
		pace         = 2'h0;
		tx_ready_out = 1'b0;
		rx_data_out  = 8'h00;
		rx_valid_out = 1'b0;
		rx_end_out   = 1'b0;
	end

	// every cycle, or two cycles in four when slow
	always @(negedge mclk_in) begin
		pace         <= pace + 2'h1;
		tx_ready_out <= !slow_in || pace[1];
	end

	// one byte strobe, then the line shows the inverse
	task automatic send_byte(input logic [7:0] b);
		@(negedge mclk_in);
		rx_data_out  = b;
		rx_valid_out = 1'b1;
		@(negedge mclk_in);
		rx_valid_out = 1'b0;
		rx_data_out  = ~b;
	endtask : send_byte

	// end of packet after the last byte
	task automatic end_pkt();
		@(negedge mclk_in);
		rx_end_out = 1'b1;
		@(negedge mclk_in);
		rx_end_out = 1'b0;
	endtask : end_pkt
endmodule : rmsc_modem_model

`default_nettype wire

/* verif/testbench.sv */
`default_nettype none

module testbench;
	timeunit 1ns;
	timeprecision 1ps;

	logic        mclk_in, rst_in, wr_en_in, rd_en_in, crc_enable_in, fifo_mode_select_in;
	logic        bandwidth_select_in, slow, rdata_valid_out, tx_valid_out, tx_ready_in;
	logic        rx_valid_in, rx_end_in, regulator_en_out, xtal_en_out, vco_en_out, pll_en_out;
	logic        rx_en_out, tx_en_out, radio_soft_reset_out, cgr_tick_out;
	logic [11:0] addr_in;
	logic [7:0]  wdata_in, rdata_out, tx_data_out, rx_data_in, base_integer_part_out, seed, ch;
	logic [3:0]  ref_divider_in, syck_div_out;
	logic [15:0] base_fraction_part_out, c;
	logic [22:0] lo_offset_out;
	logic [12:0] lo_frequency_out;
	logic [7:0]  exp_rd[$], exp_tx[$], pay[3];
	logic [4:0]  en_tab[6] = '{5'h00, 5'h00, 5'h10, 5'h1C, 5'h1E, 5'h1D};
	logic [7:0]  md_tab[6] = '{8'h00, 8'h10, 8'h18, 8'h1C, 8'h1D, 8'h1F};
	int          miscompares, n_checks, cyc, n;

	rmsc_top u_dut (.mclk_in, .rst_in, .addr_in, .wr_en_in, .rd_en_in, .wdata_in, .rdata_out,
		.rdata_valid_out, .crc_enable_in, .fifo_mode_select_in, .ref_divider_in, .bandwidth_select_in,
		.tx_data_out, .tx_valid_out, .tx_ready_in, .rx_data_in, .rx_valid_in, .rx_end_in,
		.regulator_en_out, .xtal_en_out, .vco_en_out, .pll_en_out, .rx_en_out, .tx_en_out,
		.radio_soft_reset_out, .base_integer_part_out, .base_fraction_part_out, .lo_offset_out,
		.lo_frequency_out, .cgr_tick_out, .syck_div_out);

	rmsc_modem_model u_modem (.mclk_in, .slow_in(slow), .tx_ready_out(tx_ready_in),
		.rx_data_out(rx_data_in), .rx_valid_out(rx_valid_in), .rx_end_out(rx_end_in));

	initial begin
		mclk_in = 1'b0;
		forever #2 mclk_in = ~mclk_in;
	end

	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		n_checks++;
		if (seen !== exp) begin
			miscompares++;
			$display("[ERR] %0t seen %0h expected %0h", $time, seen, exp);
		end
	endtask : check

	task automatic final_report();
		$display("checks %0d mismatches %0d", n_checks, miscompares);
		if (miscompares == 0 && n_checks > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask : final_report

	function automatic logic [7:0] rnd();
		seed = {seed[6:0], seed[7] ^ seed[5] ^ seed[4] ^ seed[3]};
		return seed;
	endfunction : rnd

	function automatic logic [15:0] crc_step(input logic [15:0] x, input logic [7:0] d);
		for (int i = 7; i >= 0; i--) begin
			x = (x[15] ^ d[i]) ? ({x[14:0], 1'b0} ^ 16'h1021) : {x[14:0], 1'b0};
		end
		return x;
	endfunction : crc_step

	task automatic bus(input logic w, input logic [11:0] a, input logic [7:0] d);
		@(negedge mclk_in);
		addr_in  = a;
		wdata_in = d;
		wr_en_in = w;
		rd_en_in = !w;
		@(negedge mclk_in);
		wr_en_in = 1'b0;
		rd_en_in = 1'b0;
	endtask : bus

	task automatic rd(input logic [11:0] a, input logic [7:0] e);
		exp_rd.push_back(e);
		bus(1'b0, a, 8'h00);
	endtask : rd

	task automatic state_is(input logic [4:0] e);
		repeat (3) @(negedge mclk_in);
		check({xtal_en_out, vco_en_out, pll_en_out, rx_en_out, tx_en_out}, e);
		check(regulator_en_out, 1);
		check(rx_en_out & tx_en_out, 0);
	endtask : state_is

	task automatic tick_count(input int e);
		n = 0;
		repeat (20) @(negedge mclk_in);
		repeat (8 * e) begin
			@(negedge mclk_in);
			n += int'(cgr_tick_out);
		end
		check(n, 8);
	endtask : tick_count

	always @(negedge mclk_in) begin
		if (rdata_valid_out === 1'b1) begin
			if (exp_rd.size() == 0) begin
				check(1, 0);
			end else begin
				check(rdata_out, exp_rd.pop_front());
			end
		end
	end

	always @(posedge mclk_in) begin
		if (tx_valid_out === 1'b1 && tx_ready_in === 1'b1) begin
			if (exp_tx.size() == 0) begin
				check(1, 0);
			end else begin
				check(tx_data_out, exp_tx.pop_front());
			end
		end
	end

	always @(posedge mclk_in) begin
		cyc++;
		if (cyc == 20000) begin
			miscompares++;
			final_report();
		end
	end

	initial begin
		{wr_en_in, rd_en_in, crc_enable_in, fifo_mode_select_in, bandwidth_select_in, slow} = 6'h00;
		addr_in = 12'h000;
		wdata_in = 8'h00;
		ref_divider_in = 4'h7;
		seed = 8'h2D;
		rst_in = 1'b1;
		repeat (2) @(posedge mclk_in);
		@(negedge mclk_in);
		rst_in = 1'b0;
		check(lo_frequency_out, 13'h12C0);
		state_is(5'h10);
		// all six codes, then a foreign nibble that must change nothing
		for (int k = 0; k < 6; k++) begin
			bus(1'b1, 12'h801, {4'(8 + k), 4'(rnd())});
			state_is(en_tab[k]);
			rd(12'h800, md_tab[k]);
			bus(1'b1, 12'h801, {4'(k < 4 ? k : k + 10), 4'(rnd())});
			state_is(en_tab[k]);
		end
		bus(1'b1, 12'h801, 8'hA0);
		ch = rnd();
		bus(1'b1, 12'h811, ch);
		bus(1'b1, 12'h812, 8'h96);
		bus(1'b1, 12'h813, 8'h04);
		bus(1'b1, 12'h814, 8'h10);
		repeat (3) @(negedge mclk_in);
		check(lo_frequency_out, 13'd4800 + 13'(ch));
		check(lo_offset_out, 23'(ch) * 23'h800);
		check(base_integer_part_out, 8'h96);
		check(base_fraction_part_out, 16'h0004);
		rd(12'h811, ch);
		rd(12'h814, 8'h10);
		rd(12'h801, 8'h00);
		rd(12'h820, 8'h00);
		for (int k = 0; k < 2; k++) begin
			ref_divider_in = k ? 4'h3 : 4'h7;
			bandwidth_select_in = 1'(k);
			tick_count(k ? 4 : 8);
			check(syck_div_out, k ? 8 : 4);
		end
		fifo_mode_select_in = 1'b1;
		for (int k = 0; k < 3; k++) begin
			pay[k] = rnd();
			bus(1'b1, 12'h900 + 12'(k), pay[k]);
		end
		// with crc and a slow modem, then without crc at full pace
		for (int k = 0; k < 2; k++) begin
			crc_enable_in = !k;
			slow = !k;
			c = 16'hFFFF;
			foreach (pay[i]) begin
				exp_tx.push_back(pay[i]);
				c = crc_step(c, pay[i]);
			end
			if (k == 0) begin
				exp_tx.push_back(c[15:8]);
				exp_tx.push_back(c[7:0]);
			end
			bus(1'b1, 12'h801, {4'hD, 4'(rnd())});
			repeat (2) @(negedge mclk_in);
			for (n = 0; n < 200 && tx_en_out !== 1'b0; n++) begin
				@(negedge mclk_in);
			end
			check(exp_tx.size(), 0);
			state_is(5'h10);
		end
		crc_enable_in = 1'b1;
		// corrupted packet first, then a clean one
		for (int k = 0; k < 2; k++) begin
			bus(1'b1, 12'h801, 8'hC0);
			repeat (2) @(negedge mclk_in);
			c = 16'hFFFF;
			foreach (pay[i]) begin
				u_modem.send_byte(~pay[i]);
				c = crc_step(c, ~pay[i]);
			end
			u_modem.send_byte(c[15:8]);
			u_modem.send_byte(c[7:0] ^ 8'(1 - k));
			u_modem.end_pkt();
			rd(12'h800, k ? 8'h3D : 8'h1D);
		end
		rd(12'h900, ~pay[0]);
		bus(1'b1, 12'h800, 8'h80);
		n = int'(radio_soft_reset_out);
		repeat (3) begin
			@(negedge mclk_in);
			n += int'(radio_soft_reset_out);
		end
		check(n, 1);
		state_is(5'h10);
		rd(12'h800, 8'h18);
		rd(12'h811, ch);
		repeat (6) @(negedge mclk_in);
		check(exp_rd.size(), 0);
		final_report();
	end
endmodule : testbench

`default_nettype wire
